/* File: design/option_byte_config_decoder.sv */
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "option_config_defs.svh"


module option_byte_config_decoder
    import option_config_pkg::*;
(
    input  wire logic                           clock,
    input  wire logic                           sys_rst,
    input  wire logic                           clock_enable,
    input  wire option_config_pkg::reg_req_t    reg_req,
    output logic      [7:0]                     reg_rdata,
    output option_config_pkg::clock_config_t    clock_config,
    output option_config_pkg::pin_remap_t       pin_remap,
    output logic                                config_valid,
    output logic                                port_conflict
);
    import option_config_pkg::*;

    // ****************************************
    // Option byte storage
    // ****************************************
    // Power-on value only; reset leaves these bytes alone
    logic [7:0]    remap_option_byte_reg = `RST_REMAP_OPTION_BYTE;
    logic [7:0]    remap_option_byte_next;
    logic [7:0]    clock_option_byte_reg = `RST_CLOCK_OPTION_BYTE;
    logic [7:0]    clock_option_byte_next;
    logic [7:0]    oscillator_settle_option_byte_reg = `RST_OSC_SETTLE_OPTION_BYTE;
    logic [7:0]    oscillator_settle_option_byte_next;

    // ****************************************
    // Latched configuration
    // ****************************************
    logic [7:0]    remap_live_reg;
    logic [7:0]    remap_live_next;
    logic [7:0]    clock_live_reg;
    logic [7:0]    clock_live_next;
    logic [7:0]    settle_live_reg;
    logic [7:0]    settle_live_next;
    logic          in_reset_reg;
    logic          in_reset_next;
    logic          config_valid_reg;
    logic          config_valid_next;
    logic [7:0]    reg_rdata_reg;
    logic [7:0]    reg_rdata_next;
    clock_config_t clock_config_reg;
    clock_config_t clock_config_next;
    pin_remap_t    pin_remap_reg;
    pin_remap_t    pin_remap_next;
    logic          port_conflict_reg;
    logic          port_conflict_next;
    logic [12:0]   settle_half_cycles;

    function automatic logic [7:0] prescale_ratio(input logic [1:0] code);
        if (!code[`BIT_PRSC_HI])
            prescale_ratio = `PRSC_DIV_16MHZ;
        else if (!code[`BIT_PRSC_LO])
            prescale_ratio = `PRSC_DIV_8MHZ;
        else
            prescale_ratio = `PRSC_DIV_4MHZ;
    endfunction : prescale_ratio

    function automatic logic count_ones_over_one(input logic [2:0] bits);
        count_ones_over_one = (bits[0] & bits[1]) | (bits[0] & bits[2]) | (bits[1] & bits[2]);
    endfunction : count_ones_over_one

    settle_count_decode u_settle (
        .settle_code        (settle_live_reg),
        .settle_half_cycles (settle_half_cycles)
    );

    // ****************************************
    // Register writes and capture
    // ****************************************
    always_comb begin
        remap_option_byte_next             = remap_option_byte_reg;
        clock_option_byte_next             = clock_option_byte_reg;
        oscillator_settle_option_byte_next = oscillator_settle_option_byte_reg;
        remap_live_next                    = remap_live_reg;
        clock_live_next                    = clock_live_reg;
        settle_live_next                   = settle_live_reg;
        in_reset_next                      = 1'b0;
        config_valid_next                  = config_valid_reg;
        // Option bytes are writable whenever the enable is high; new values act after a reset
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                `OFS_REMAP_OPTION_BYTE:      remap_option_byte_next = reg_req.wdata;
                `OFS_CLOCK_OPTION_BYTE:      clock_option_byte_next = reg_req.wdata;
                `OFS_OSC_SETTLE_OPTION_BYTE: oscillator_settle_option_byte_next = reg_req.wdata;
                default: ;
            endcase
        end
        if (in_reset_reg) begin
            remap_live_next   = remap_option_byte_reg;
            clock_live_next   = clock_option_byte_reg;
            settle_live_next  = oscillator_settle_option_byte_reg;
            config_valid_next = 1'b1;
        end
    end

    // ****************************************
    // Decode of latched settings
    // ****************************************
    always_comb begin
        clock_config_next.osc_mode = clock_live_reg[`BIT_EXT_CLOCK_SELECT] ?
                                     OSC_EXT_CLOCK : OSC_CRYSTAL;
        clock_config_next.oscillator_output_pin_enable = ~clock_live_reg[`BIT_EXT_CLOCK_SELECT];
        clock_config_next.wake_src = clock_live_reg[`BIT_WAKEUP_SRC_SELECT] ?
                                     WAKE_SRC_HIGH_SPEED_EXTERNAL : WAKE_SRC_LOW_SPEED_INTERNAL;
        clock_config_next.wakeup_prescale_ratio =
            prescale_ratio(clock_live_reg[`BIT_PRSC_HI:`BIT_PRSC_LO]);
        clock_config_next.settle_half_cycles = settle_half_cycles;

        pin_remap_next.c3_timer_one_ch1_inverted        = remap_live_reg[`BIT_REMAP_SEVEN];
        pin_remap_next.c4_timer_one_ch2_inverted        = remap_live_reg[`BIT_REMAP_SEVEN];
        pin_remap_next.d7_timer_one_ch4                 = remap_live_reg[`BIT_REMAP_SIX];
        pin_remap_next.d0_configurable_clock_output     = remap_live_reg[`BIT_REMAP_FIVE];
        pin_remap_next.b4_adc_external_trigger          = remap_live_reg[`BIT_REMAP_FOUR];
        pin_remap_next.b5_timer_one_break_input         = remap_live_reg[`BIT_REMAP_FOUR];
        pin_remap_next.c3_top_level_interrupt_input     = remap_live_reg[`BIT_REMAP_THREE];
        pin_remap_next.c4_analog_input_two              = remap_live_reg[`BIT_REMAP_TWO];
        pin_remap_next.d2_analog_input_three            = remap_live_reg[`BIT_REMAP_TWO];
        pin_remap_next.d4_serial_interface_clock_output = remap_live_reg[`BIT_REMAP_TWO];
        // flag same-port overlap
        // Port C: seven, three, two; port D: six, five, two. Flag only, no override.
        port_conflict_next =
            count_ones_over_one({remap_live_reg[`BIT_REMAP_SEVEN],
                                 remap_live_reg[`BIT_REMAP_THREE],
                                 remap_live_reg[`BIT_REMAP_TWO]}) |
            count_ones_over_one({remap_live_reg[`BIT_REMAP_SIX],
                                 remap_live_reg[`BIT_REMAP_FIVE],
                                 remap_live_reg[`BIT_REMAP_TWO]});
    end

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        reg_rdata_next = 8'h00;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                `OFS_REMAP_OPTION_BYTE:      reg_rdata_next = remap_option_byte_reg;
                `OFS_CLOCK_OPTION_BYTE:      reg_rdata_next = clock_option_byte_reg;
                `OFS_OSC_SETTLE_OPTION_BYTE: reg_rdata_next = oscillator_settle_option_byte_reg;
                `OFS_STATUS:          reg_rdata_next = {6'h00, port_conflict_reg, config_valid_reg};
                `OFS_REMAP_ACTIVE:    reg_rdata_next = remap_live_reg;
                `OFS_SETTLE_CYCLES_LO: reg_rdata_next = clock_config_reg.settle_half_cycles[7:0];
                `OFS_SETTLE_CYCLES_HI:
                    reg_rdata_next = {3'h0, clock_config_reg.settle_half_cycles[12:8]};
                default:              reg_rdata_next = 8'h00;
            endcase
        end
    end

    // ****************************************
    // State registers
    // ****************************************
    // Reset waits for the enable too, so a frozen block stays frozen
    always_ff @(posedge clock) begin
        if (clock_enable) begin
            if (sys_rst) begin
                // Option bytes stand in for nonvolatile storage: reset leaves them
                in_reset_reg      <= 1'b1;
                config_valid_reg  <= 1'b0;
                reg_rdata_reg     <= 8'h00;
                remap_live_reg    <= `RST_REMAP_OPTION_BYTE;
                clock_live_reg    <= `RST_CLOCK_OPTION_BYTE;
                settle_live_reg   <= `RST_OSC_SETTLE_OPTION_BYTE;
            end else begin
                in_reset_reg      <= in_reset_next;
                config_valid_reg  <= config_valid_next;
                reg_rdata_reg     <= reg_rdata_next;
                remap_live_reg    <= remap_live_next;
                clock_live_reg    <= clock_live_next;
                settle_live_reg   <= settle_live_next;
            end
        end
    end

    // Held across reset on purpose
    always_ff @(posedge clock) begin
        if (clock_enable) begin
            remap_option_byte_reg             <= remap_option_byte_next;
            clock_option_byte_reg             <= clock_option_byte_next;
            oscillator_settle_option_byte_reg <= oscillator_settle_option_byte_next;
        end
    end

    always_ff @(posedge clock) begin
        if (clock_enable) begin
            if (sys_rst) begin
                clock_config_reg  <= '0;
                pin_remap_reg     <= '0;
                port_conflict_reg <= 1'b0;
            end else begin
                clock_config_reg  <= clock_config_next;
                pin_remap_reg     <= pin_remap_next;
                port_conflict_reg <= port_conflict_next;
            end
        end
    end

    assign reg_rdata     = reg_rdata_reg;
    assign clock_config  = clock_config_reg;
    assign pin_remap     = pin_remap_reg;
    assign config_valid  = config_valid_reg;
    assign port_conflict = port_conflict_reg;

endmodule : option_byte_config_decoder

/* File: design/option_config_defs.svh */
`ifndef OPTION_CONFIG_DEFS_SVH
`define OPTION_CONFIG_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_REMAP_OPTION_BYTE        4'h0
`define OFS_CLOCK_OPTION_BYTE        4'h1
`define OFS_OSC_SETTLE_OPTION_BYTE   4'h2
`define OFS_STATUS                   4'h3
`define OFS_REMAP_ACTIVE             4'h4
`define OFS_SETTLE_CYCLES_LO         4'h5
`define OFS_SETTLE_CYCLES_HI         4'h6

// ****************************************
// Power-on values of the option bytes
// ****************************************
`define RST_REMAP_OPTION_BYTE        8'h00
`define RST_CLOCK_OPTION_BYTE        8'h00
`define RST_OSC_SETTLE_OPTION_BYTE   8'h00

// ****************************************
// Field positions
// ****************************************
`define BIT_EXT_CLOCK_SELECT         3
`define BIT_WAKEUP_SRC_SELECT        2
`define BIT_PRSC_HI                  1
`define BIT_PRSC_LO                  0
`define BIT_REMAP_SEVEN              7
`define BIT_REMAP_SIX                6
`define BIT_REMAP_FIVE               5
`define BIT_REMAP_FOUR               4
`define BIT_REMAP_THREE              3
`define BIT_REMAP_TWO                2

// ****************************************
// Settle codes and counts
// ****************************************
`define SETTLE_CODE_2048             8'h00
`define SETTLE_CODE_128              8'hb4
`define SETTLE_CODE_8                8'hd2
`define SETTLE_CODE_HALF             8'he1
`define SETTLE_HALF_CYCLES_2048      13'h1000
`define SETTLE_HALF_CYCLES_128       13'h0100
`define SETTLE_HALF_CYCLES_8         13'h0010
`define SETTLE_HALF_CYCLES_HALF      13'h0001

// ****************************************
// Wakeup prescaler divide ratios
// ****************************************
`define PRSC_DIV_16MHZ               8'h7d
`define PRSC_DIV_8MHZ                8'h3e
`define PRSC_DIV_4MHZ                8'h1f

`endif

/* File: design/option_config_pkg.sv */
package option_config_pkg;

    typedef enum logic {
        OSC_CRYSTAL,
        OSC_EXT_CLOCK
    } osc_mode_t;

    typedef enum logic {
        WAKE_SRC_LOW_SPEED_INTERNAL,
        WAKE_SRC_HIGH_SPEED_EXTERNAL
    } wake_src_t;

    typedef struct packed {
        osc_mode_t   osc_mode;
        logic        oscillator_output_pin_enable;
        wake_src_t   wake_src;
        logic [7:0]  wakeup_prescale_ratio;
        logic [12:0] settle_half_cycles;
    } clock_config_t;

    typedef struct packed {
        logic c3_timer_one_ch1_inverted;
        logic c4_timer_one_ch2_inverted;
        logic d7_timer_one_ch4;
        logic d0_configurable_clock_output;
        logic b4_adc_external_trigger;
        logic b5_timer_one_break_input;
        logic c3_top_level_interrupt_input;
        logic c4_analog_input_two;
        logic d2_analog_input_three;
        logic d4_serial_interface_clock_output;
    } pin_remap_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

endpackage : option_config_pkg

/* File: design/settle_count_decode.sv */
`timescale 1ns/1ns
`include "option_config_defs.svh"

module settle_count_decode (
    input  wire logic [7:0]  settle_code,
    output logic      [12:0] settle_half_cycles
);
    // ****************************************
    // Settle code lookup
    // ****************************************
    // code to half cycles
    always_comb begin
        unique case (settle_code)
            `SETTLE_CODE_128:  settle_half_cycles = `SETTLE_HALF_CYCLES_128;
            `SETTLE_CODE_8:    settle_half_cycles = `SETTLE_HALF_CYCLES_8;
            `SETTLE_CODE_HALF: settle_half_cycles = `SETTLE_HALF_CYCLES_HALF;
            // Unlisted codes fall back to the longest, safest wait
            default:           settle_half_cycles = `SETTLE_HALF_CYCLES_2048;
        endcase
    end

endmodule : settle_count_decode

/* File: tb/option_byte_config_decoder_asserts.sv */
`timescale 1ns/1ns
module option_byte_config_decoder_asserts
    import option_config_pkg::*;
(
    input wire logic                             clock,
    input wire logic                             sys_rst,
    input wire logic                             clock_enable,
    input wire option_config_pkg::reg_req_t      reg_req,
    input wire logic                       [7:0] reg_rdata,
    input wire option_config_pkg::clock_config_t clock_config,
    input wire option_config_pkg::pin_remap_t    pin_remap,
    input wire logic                             config_valid,
    input wire logic                             port_conflict
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // ****************************************
    // Decoded configuration, reset and read data
    // ****************************************
    a_osc_pin_use: assert property (
        config_valid && $past(config_valid) |-> clock_config.oscillator_output_pin_enable
        == (clock_config.osc_mode == OSC_CRYSTAL)) else $error("oscillator pin use wrong");
    a_prescale_code: assert property (
        config_valid && $past(config_valid) |-> clock_config.wakeup_prescale_ratio
        inside {8'h7d, 8'h3e, 8'h1f}) else $error("prescale ratio outside its set");
    a_settle_code: assert property (
        config_valid && $past(config_valid) |-> clock_config.settle_half_cycles
        inside {13'h1000, 13'h0100, 13'h0010, 13'h0001}) else $error("settle count bad");
    a_remap_pairs: assert property (
        pin_remap.c3_timer_one_ch1_inverted == pin_remap.c4_timer_one_ch2_inverted
        && pin_remap.b4_adc_external_trigger == pin_remap.b5_timer_one_break_input
        && pin_remap.c4_analog_input_two == pin_remap.d2_analog_input_three
        && pin_remap.d2_analog_input_three == pin_remap.d4_serial_interface_clock_output)
        else $error("remap pin pair split");
    a_conflict_flag: assert property (
        config_valid && $past(config_valid) |-> port_conflict ==
        ($countones({pin_remap.c3_timer_one_ch1_inverted, pin_remap.c3_top_level_interrupt_input,
        pin_remap.c4_analog_input_two}) > 1 || $countones({pin_remap.d7_timer_one_ch4,
        pin_remap.d0_configurable_clock_output, pin_remap.d2_analog_input_three}) > 1))
        else $error("port conflict flag wrong");
    a_config_hold: assert property (
        config_valid && $past(config_valid) |=> $stable(clock_config) && $stable(pin_remap)
        && $stable(port_conflict)) else $error("configuration changed without reset");
    a_valid_rise: assert property (
        $fell(sys_rst) && clock_enable && $past(clock_enable) |=> config_valid)
        else $error("config valid late after reset");
    a_reset_clear: assert property (disable iff (1'b0)
        sys_rst && clock_enable |=> !config_valid && !port_conflict && pin_remap == 10'h000)
        else $error("reset did not clear outputs");
    a_rdata_idle: assert property (
        $past(clock_enable) && !$past(reg_req.rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");

    c_valid: cover property ($fell(sys_rst) ##2 config_valid);
    c_conflict: cover property (config_valid && port_conflict);
    c_read: cover property ($past(reg_req.rd) && reg_rdata != 8'h00);
endmodule : option_byte_config_decoder_asserts

bind option_byte_config_decoder option_byte_config_decoder_asserts
    i_option_byte_config_decoder_asserts (.clock(clock), .sys_rst(sys_rst),
    .clock_enable(clock_enable), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .clock_config(clock_config), .pin_remap(pin_remap), .config_valid(config_valid),
    .port_conflict(port_conflict));

/* File: tb/pin_mux_model.sv */
`timescale 1ns/1ns
module pin_mux_model
    import option_config_pkg::*;
(
    input wire option_config_pkg::pin_remap_t       pin_remap,
    output logic                              [1:0] c3_func,
    output logic                              [1:0] c4_func
);
    // ****************************************
    // Port C function select
    // ****************************************
    // C3 choice
    assign c3_func = pin_remap.c3_timer_one_ch1_inverted ? 2'h1 :
                     (pin_remap.c3_top_level_interrupt_input ? 2'h2 : 2'h0);
    assign c4_func = pin_remap.c4_timer_one_ch2_inverted ? 2'h1 :
                     (pin_remap.c4_analog_input_two ? 2'h2 : 2'h0);
endmodule : pin_mux_model

/* File: tb/option_byte_config_decoder_bench.sv */
`timescale 1ns/1ns
module option_byte_config_decoder_bench;
    import option_config_pkg::*;
    logic                clock = 1'b0;
    logic                sys_rst = 1'b1;
    logic                clock_enable = 1'b1;
    reg_req_t            req = '0;
    logic          [7:0] reg_rdata;
    clock_config_t       clock_config;
    pin_remap_t          pin_remap;
    logic                config_valid;
    logic                port_conflict;
    logic          [1:0] c3_func;
    logic          [1:0] c4_func;
    clock_config_t       e_cc;
    pin_remap_t          e_pr;
    logic                e_pc;
    logic          [7:0] rm;
    logic          [7:0] ck;
    logic          [7:0] st;
    logic          [7:0] stab [4] = '{8'h00, 8'hb4, 8'hd2, 8'he1};
    logic                rd_seen = 1'b0;
    logic          [7:0] exp_q [$];
    int                  err_count = 0;
    int                  cmp_count = 0;

    always #2 clock = ~clock;

    option_byte_config_decoder i_option_byte_config_decoder (.clock(clock), .sys_rst(sys_rst),
        .clock_enable(clock_enable), .reg_req(req), .reg_rdata(reg_rdata),
        .clock_config(clock_config), .pin_remap(pin_remap), .config_valid(config_valid),
        .port_conflict(port_conflict));
    pin_mux_model i_pin_mux_model (.pin_remap(pin_remap), .c3_func(c3_func), .c4_func(c4_func));

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude();
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task automatic op(input logic [3:0] a, input logic [7:0] d, input logic w, input logic r);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask : op

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        op(a, 8'h00, 1'b0, 1'b1);
    endtask : rd

    // Reset holds two edges; outputs are decoded two edges after release
    task automatic do_reset();
        op(4'h0, 8'h00, 1'b0, 1'b0);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask : do_reset

    task automatic expect_cfg();
        e_cc.osc_mode = ck[3] ? OSC_EXT_CLOCK : OSC_CRYSTAL;
        e_cc.oscillator_output_pin_enable = ~ck[3];
        e_cc.wake_src = ck[2] ? WAKE_SRC_HIGH_SPEED_EXTERNAL : WAKE_SRC_LOW_SPEED_INTERNAL;
        e_cc.wakeup_prescale_ratio = !ck[1] ? 8'h7d : (ck[0] ? 8'h1f : 8'h3e);
        case (st)
            8'hb4: e_cc.settle_half_cycles = 13'h0100;
            8'hd2: e_cc.settle_half_cycles = 13'h0010;
            8'he1: e_cc.settle_half_cycles = 13'h0001;
            default: e_cc.settle_half_cycles = 13'h1000;
        endcase
        e_pr = {rm[7], rm[7], rm[6], rm[5], rm[4], rm[4], rm[3], rm[2], rm[2], rm[2]};
        e_pc = ($countones({rm[7], rm[3], rm[2]}) > 1) || ($countones({rm[6], rm[5], rm[2]}) > 1);
    endtask : expect_cfg

    task automatic chk_out();
        chk(clock_config, e_cc);
        chk(pin_remap, e_pr);
        chk({port_conflict, config_valid}, {e_pc, 1'b1});
        chk(c3_func, e_pr[9] ? 2'h1 : {e_pr[3], 1'b0});
        chk(c4_func, e_pr[8] ? 2'h1 : {e_pr[2], 1'b0});
    endtask : chk_out

    // Read data stands only in the cycle after the strobe
    always @(posedge clock) begin
        if (rd_seen) begin
            chk(reg_rdata, exp_q.pop_front());
        end
        rd_seen <= req.rd && clock_enable;
    end

    initial begin
        #100000;
        err_count++;
        conclude();
    end

    initial begin
        void'($urandom(32'hbfda84e8));
        rm = 8'h00;
        ck = 8'h00;
        st = 8'h00;
        do_reset();
        expect_cfg();
        chk_out();
        for (int i = 0; i < 16; i++) begin
            // first six set one remap, next two none, rest probe the flag
            rm = (i < 8) ? ((8'h80 >> i) & 8'hfc) : (8'($urandom) & 8'hfc);
            ck = 8'(i);
            st = i[2] ? 8'($urandom) : stab[i[1:0]];
            op(4'h0, rm, 1'b1, 1'b0);
            op(4'h1, ck, 1'b1, 1'b0);
            op(4'h2, st, 1'b1, 1'b0);
            op(4'h3, 8'hff, 1'b1, 1'b0);
            op(4'h9, 8'h5a, 1'b1, 1'b0);
            rd(4'h0, rm);
            rd(4'h1, ck);
            rd(4'h2, st);
            rd(4'h9, 8'h00);
            rd(4'h3, {6'h00, e_pc, 1'b1});
            op(4'h0, 8'h00, 1'b0, 1'b0);
            @(posedge clock);
            #1;
            // Option writes must wait for the next reset
            chk_out();
            do_reset();
            expect_cfg();
            chk_out();
            rd(4'h4, rm);
            rd(4'h5, e_cc.settle_half_cycles[7:0]);
            rd(4'h6, {3'h0, e_cc.settle_half_cycles[12:8]});
        end
        // A write with the enable low is lost
        op(4'h0, ~rm & 8'hfc, 1'b1, 1'b0);
        clock_enable <= 1'b0;
        op(4'h0, 8'h00, 1'b0, 1'b0);
        clock_enable <= 1'b1;
        rd(4'h0, rm);
        op(4'h0, 8'h00, 1'b0, 1'b0);
        repeat (2) @(posedge clock);
        conclude();
    end
endmodule : option_byte_config_decoder_bench
